// [gpb_pins.sv]
// Purpose: outside pins and alternate peripheral of the port
// Assumes: outside source drives every pin the port leaves free
// Notes: peripheral drives a fixed pattern on all pins
`timescale 1ns/10ps
module gpb_pins (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in,
  output logic [7:0] periph_out,
  output logic [7:0] periph_oe
);
  // ----------
  // wire level
  // ----------
  // source changes only when the bench says so
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
  assign periph_out = 8'hA5;
  assign periph_oe = 8'hFF;
endmodule : gpb_pins

// [gpb_pkg.sv]
// Purpose: shared constants and carriers of the eight-pin port
// Assumes: 32-bit register bus, 12-bit byte address window
// Notes: identity bytes and lock key are arbitrary values
package gpb_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_DIR = 12'h400;
  localparam logic [11:0] OFF_SENSE = 12'h404;
  localparam logic [11:0] OFF_BOTH = 12'h408;
  localparam logic [11:0] OFF_POL = 12'h40C;
  localparam logic [11:0] OFF_MASK = 12'h410;
  localparam logic [11:0] OFF_RAW = 12'h414;
  localparam logic [11:0] OFF_GATED = 12'h418;
  localparam logic [11:0] OFF_CLEAR = 12'h41C;
  localparam logic [11:0] OFF_PSEL = 12'h420;
  localparam logic [11:0] OFF_DRV_LOW = 12'h500;
  localparam logic [11:0] OFF_DRV_MID = 12'h504;
  localparam logic [11:0] OFF_DRV_HIGH = 12'h508;
  localparam logic [11:0] OFF_OPEN_DRAIN = 12'h50C;
  localparam logic [11:0] OFF_PULL_UP = 12'h510;
  localparam logic [11:0] OFF_PULL_DOWN = 12'h514;
  localparam logic [11:0] OFF_SLEW = 12'h518;
  localparam logic [11:0] OFF_DIG_EN = 12'h51C;
  localparam logic [11:0] OFF_GUARD = 12'h520;
  localparam logic [11:0] OFF_COMMIT = 12'h524;
  // identity words occupy the top twelve words of the window
  localparam logic [5:0] ID_PAGE = 6'h3F;
  localparam logic [3:0] ID_FIRST = 4'h4;

  // ----------------------------------------------------------------
  // reset values and port variants
  // ----------------------------------------------------------------
  localparam logic [1:0] PORT_PLAIN = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [7:0] DBG_PINS_B = 8'h80;
  localparam logic [7:0] DBG_PINS_C = 8'h0F;
  localparam logic [7:0] DRV_LOW_RST = 8'hFF;
  localparam logic [7:0] COMMIT_RST = 8'hFF;
  localparam logic [2:0] TRIG_PIN = 3'h4;
  // arbitrary key value
  localparam logic [31:0] GUARD_KEY = 32'h1ACC_E55A;
  localparam logic [31:0] GUARD_LOCKED = 32'h0000_0001;
  localparam logic [3:0] STRB_ALL = 4'hF;
  // arbitrary identity bytes, word 0 in the low byte
  localparam logic [95:0] ID_BYTES = 96'h5A3C_9601_0000_0000_0011_2233;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } gpb_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpb_axi_rsp_t;

  typedef struct packed {
    logic [7:0] drive_low_select;
    logic [7:0] drive_mid_select;
    logic [7:0] drive_high_select;
    logic [7:0] open_drain_select;
    logic [7:0] pull_up_select;
    logic [7:0] pull_down_select;
    logic [7:0] slew_select;
    logic [7:0] digital_input_enable;
  } gpb_pad_t;

endpackage : gpb_pkg

// [gpb_port.sv]
// Purpose: eight-pin general-purpose port with interrupt unit
// Assumes: AXI4-Lite slave, one 25 MHz clock, async active-low reset
// Notes: PORT_KIND picks plain, port-B or port-C debug pin layout
// Operation
// RULE_01: ordinary pins reset undriven, settings cleared
// RULE_02: debug pins reset to debug function
// RULE_03: every reset restores both default groups
// RULE_04: input pins load the value register
// RULE_05: output pins drive the value register
// RULE_06: address bits nine to two mask data
// RULE_07: masked writes change only selected bits
// RULE_08: masked reads return zero for unselected bits
// RULE_09: one port interrupt from all pins
// RULE_10: edge events stay latched until cleared
// RULE_11: level sources hold level until serviced
// RULE_12: rising, falling, both, high or low
// RULE_13: sense, both-edge and polarity bit encoding
// RULE_14: mask gates gated status and interrupt
// RULE_15: raw status ignores the mask
// RULE_16: writing one clears pending edge event
// RULE_17: port B pin four triggers converter
// RULE_18: software masks before changing sense settings
// RULE_19: peripheral select hands pin to peripheral
// RULE_20: debug select writes need unlock and allow
// RULE_21: debug allow bits reset zero, others one
// RULE_22: pad drive, pull, slew, input enable outputs
// RULE_23: read-only identity words
// RULE_24: key unlocks, anything else relocks
// RULE_25: pins synchronised before edge detection
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module gpb_port #(
  parameter logic [1:0] PORT_KIND = gpb_pkg::PORT_PLAIN
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire gpb_pkg::gpb_axi_req_t axi_req,
  output gpb_pkg::gpb_axi_rsp_t axi_rsp,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  output logic [7:0] periph_in,
  output gpb_pkg::gpb_pad_t pad_cfg,
  output logic irq,
  output logic adc_trig
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] dbg_mask(input logic [1:0] kind);
    logic [7:0] m;
    m = 8'h00;
    if (kind == gpb_pkg::PORT_B) begin
      m = gpb_pkg::DBG_PINS_B;
    end else if (kind == gpb_pkg::PORT_C) begin
      m = gpb_pkg::DBG_PINS_C;
    end
    return m;
  endfunction : dbg_mask

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] sel);
    return (old_v & ~sel) | (new_v & sel);
  endfunction : merge

  localparam logic [7:0] DBG = dbg_mask(PORT_KIND);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] pin_value_register;
    logic [7:0] pin_direction_bits;
    logic [7:0] irq_sense_select;
    logic [7:0] irq_both_edge_select;
    logic [7:0] irq_polarity_select;
    logic [7:0] irq_enable_mask;
    logic [7:0] edge_latch;
    logic [7:0] peripheral_select_bits;
    logic [7:0] drv_low;
    logic [7:0] drv_mid;
    logic [7:0] drv_high;
    logic [7:0] open_drain;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
    logic [7:0] slew;
    logic [7:0] dig_en;
    logic unlocked;
    logic [7:0] commit_allow_bits;
    logic [7:0] prev_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] periph_in;
    logic irq;
    logic trig_seen;
    logic adc_trig;
  } gpb_state_t;

  function automatic gpb_state_t reset_state();
    gpb_state_t s;
    s = '0;
    s.awready = 1'b1;
    s.wready = 1'b1;
    s.arready = 1'b1;
    s.peripheral_select_bits = DBG; // RULE_01 RULE_02
    s.pull_up = DBG; // RULE_01 RULE_02
    s.dig_en = DBG; // RULE_01 RULE_02
    s.drv_low = gpb_pkg::DRV_LOW_RST;
    s.commit_allow_bits = gpb_pkg::COMMIT_RST & ~DBG; // RULE_21
    return s;
  endfunction : reset_state

  localparam gpb_state_t RST_ST = reset_state();

  gpb_state_t st;
  gpb_state_t next_st;
  logic [7:0] sync_level;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  gpb_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pin_in),
    .level(sync_level)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [7:0] in_now;
  logic [7:0] evt;
  logic [7:0] raw;
  logic [7:0] gated;
  logic [7:0] clr;
  logic [7:0] wd8;
  logic [7:0] allow;
  logic [7:0] out_v;
  logic [7:0] oe_v;
  logic [11:0] wa;
  logic [11:0] ra;
  logic [31:0] rd;
  logic w_ok;
  logic r_ok;

  always_comb begin
    next_st = st;
    clr = 8'h00;
    allow = 8'h00;
    w_ok = 1'b1;
    r_ok = 1'b1;
    rd = 32'h0000_0000;
    wa = st.awaddr;
    ra = axi_req.araddr;
    wd8 = st.wdata[7:0];
    next_st.adc_trig = 1'b0;

    // digital input disabled reads as low
    in_now = sync_level & st.dig_en; // RULE_22
    next_st.periph_in = in_now;

    next_st.pin_value_register = merge(st.pin_value_register, in_now,
                                       ~st.pin_direction_bits); // RULE_04

    // interrupt sense: edge events latch, levels follow the pin
    evt = (st.irq_both_edge_select & (in_now ^ st.prev_in)) |
          (~st.irq_both_edge_select & st.irq_polarity_select &
           in_now & ~st.prev_in) |
          (~st.irq_both_edge_select & ~st.irq_polarity_select &
           ~in_now & st.prev_in); // RULE_12 RULE_13
    evt = evt & ~st.irq_sense_select; // RULE_13
    raw = (st.irq_sense_select & ~(in_now ^ st.irq_polarity_select)) |
          (~st.irq_sense_select & st.edge_latch); // RULE_12 RULE_15
    gated = raw & st.irq_enable_mask; // RULE_14
    next_st.prev_in = in_now;

    // write channel: address and data taken in either order
    if (st.awready && axi_req.awvalid) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (st.wready && axi_req.wvalid) begin
      next_st.w_held = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      // eight-bit registers use byte lane zero only
      if (wa[11:10] == 2'b00) begin
        if (st.wstrb[0]) begin
          next_st.pin_value_register = merge(
            next_st.pin_value_register, wd8, wa[9:2]); // RULE_06 RULE_07
        end
      end else if (wa == gpb_pkg::OFF_GUARD) begin
        next_st.unlocked = (st.wdata == gpb_pkg::GUARD_KEY) &&
                           (st.wstrb == gpb_pkg::STRB_ALL); // RULE_24
      end else if (wa == gpb_pkg::OFF_RAW || wa == gpb_pkg::OFF_GATED) begin
        w_ok = 1'b1;
      end else if (!st.wstrb[0]) begin
        w_ok = 1'b1;
      end else if (wa == gpb_pkg::OFF_DIR) begin
        next_st.pin_direction_bits = wd8;
      end else if (wa == gpb_pkg::OFF_SENSE) begin
        next_st.irq_sense_select = wd8;
      end else if (wa == gpb_pkg::OFF_BOTH) begin
        next_st.irq_both_edge_select = wd8;
      end else if (wa == gpb_pkg::OFF_POL) begin
        next_st.irq_polarity_select = wd8;
      end else if (wa == gpb_pkg::OFF_MASK) begin
        next_st.irq_enable_mask = wd8;
      end else if (wa == gpb_pkg::OFF_CLEAR) begin
        clr = wd8; // RULE_16
      end else if (wa == gpb_pkg::OFF_PSEL) begin
        allow = ~DBG | (st.commit_allow_bits & {8{st.unlocked}});
        next_st.peripheral_select_bits = merge(
          st.peripheral_select_bits, wd8, allow); // RULE_20
      end else if (wa == gpb_pkg::OFF_DRV_LOW) begin
        // drive strengths are one-of-three
        next_st.drv_low = wd8 | st.drv_low;
        next_st.drv_mid = st.drv_mid & ~wd8;
        next_st.drv_high = st.drv_high & ~wd8; // RULE_22
      end else if (wa == gpb_pkg::OFF_DRV_MID) begin
        next_st.drv_mid = wd8 | st.drv_mid;
        next_st.drv_low = st.drv_low & ~wd8;
        next_st.drv_high = st.drv_high & ~wd8; // RULE_22
      end else if (wa == gpb_pkg::OFF_DRV_HIGH) begin
        next_st.drv_high = wd8 | st.drv_high;
        next_st.drv_low = st.drv_low & ~wd8;
        next_st.drv_mid = st.drv_mid & ~wd8; // RULE_22
      end else if (wa == gpb_pkg::OFF_OPEN_DRAIN) begin
        next_st.open_drain = wd8;
      end else if (wa == gpb_pkg::OFF_PULL_UP) begin
        next_st.pull_up = wd8;
      end else if (wa == gpb_pkg::OFF_PULL_DOWN) begin
        next_st.pull_down = wd8;
      end else if (wa == gpb_pkg::OFF_SLEW) begin
        next_st.slew = wd8;
      end else if (wa == gpb_pkg::OFF_DIG_EN) begin
        next_st.dig_en = wd8;
      end else if (wa == gpb_pkg::OFF_COMMIT) begin
        // only the debug bits are writable, and only when unlocked
        if (st.unlocked) begin
          next_st.commit_allow_bits = merge(
            st.commit_allow_bits, wd8, DBG); // RULE_21
        end
      end else if (wa[11:6] == gpb_pkg::ID_PAGE &&
                   wa[5:2] >= gpb_pkg::ID_FIRST) begin
        w_ok = 1'b1;
      end else begin
        w_ok = 1'b0;
      end
      next_st.bresp = w_ok ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;

    // set wins over a clear arriving in the same cycle
    next_st.edge_latch = (st.edge_latch & ~clr) | evt; // RULE_10 RULE_16

    // read channel
    if (st.arready && axi_req.arvalid) begin
      if (ra[11:10] == 2'b00) begin
        rd[7:0] = st.pin_value_register & ra[9:2]; // RULE_06 RULE_08
      end else if (ra == gpb_pkg::OFF_DIR) begin
        rd[7:0] = st.pin_direction_bits;
      end else if (ra == gpb_pkg::OFF_SENSE) begin
        rd[7:0] = st.irq_sense_select;
      end else if (ra == gpb_pkg::OFF_BOTH) begin
        rd[7:0] = st.irq_both_edge_select;
      end else if (ra == gpb_pkg::OFF_POL) begin
        rd[7:0] = st.irq_polarity_select;
      end else if (ra == gpb_pkg::OFF_MASK) begin
        rd[7:0] = st.irq_enable_mask;
      end else if (ra == gpb_pkg::OFF_RAW) begin
        rd[7:0] = raw; // RULE_15
      end else if (ra == gpb_pkg::OFF_GATED) begin
        rd[7:0] = gated; // RULE_14
      end else if (ra == gpb_pkg::OFF_CLEAR) begin
        rd[7:0] = 8'h00;
      end else if (ra == gpb_pkg::OFF_PSEL) begin
        rd[7:0] = st.peripheral_select_bits;
      end else if (ra == gpb_pkg::OFF_DRV_LOW) begin
        rd[7:0] = st.drv_low;
      end else if (ra == gpb_pkg::OFF_DRV_MID) begin
        rd[7:0] = st.drv_mid;
      end else if (ra == gpb_pkg::OFF_DRV_HIGH) begin
        rd[7:0] = st.drv_high;
      end else if (ra == gpb_pkg::OFF_OPEN_DRAIN) begin
        rd[7:0] = st.open_drain;
      end else if (ra == gpb_pkg::OFF_PULL_UP) begin
        rd[7:0] = st.pull_up;
      end else if (ra == gpb_pkg::OFF_PULL_DOWN) begin
        rd[7:0] = st.pull_down;
      end else if (ra == gpb_pkg::OFF_SLEW) begin
        rd[7:0] = st.slew;
      end else if (ra == gpb_pkg::OFF_DIG_EN) begin
        rd[7:0] = st.dig_en;
      end else if (ra == gpb_pkg::OFF_GUARD) begin
        rd = st.unlocked ? 32'h0000_0000 : gpb_pkg::GUARD_LOCKED;
      end else if (ra == gpb_pkg::OFF_COMMIT) begin
        rd[7:0] = st.commit_allow_bits;
      end else if (ra[11:6] == gpb_pkg::ID_PAGE &&
                   ra[5:2] >= gpb_pkg::ID_FIRST) begin
        rd[7:0] = gpb_pkg::ID_BYTES[
          (ra[5:2] - gpb_pkg::ID_FIRST) * 8 +: 8]; // RULE_23
      end else begin
        r_ok = 1'b0;
      end
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = r_ok ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR;
    end else if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;

    // one port interrupt from all gated pins
    next_st.irq = |gated; // RULE_09 RULE_14

    // converter trigger: one pulse per rise of gated pin four
    if (PORT_KIND == gpb_pkg::PORT_B) begin
      next_st.trig_seen = gated[gpb_pkg::TRIG_PIN];
      next_st.adc_trig = gated[gpb_pkg::TRIG_PIN] && !st.trig_seen; // RULE_17
    end

    // pin drive; open drain only pulls low
    out_v = merge(st.pin_value_register, periph_out,
                  st.peripheral_select_bits); // RULE_05 RULE_19
    oe_v = merge(st.pin_direction_bits, periph_oe,
                 st.peripheral_select_bits); // RULE_05 RULE_19
    next_st.pin_out = out_v;
    next_st.pin_oe = oe_v & (~st.open_drain | ~out_v); // RULE_22
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= RST_ST; // RULE_03
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign axi_rsp.awready = st.awready;
  assign axi_rsp.wready = st.wready;
  assign axi_rsp.bvalid = st.bvalid;
  assign axi_rsp.bresp = st.bresp;
  assign axi_rsp.arready = st.arready;
  assign axi_rsp.rvalid = st.rvalid;
  assign axi_rsp.rdata = st.rdata;
  assign axi_rsp.rresp = st.rresp;
  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign periph_in = st.periph_in;
  assign pad_cfg.drive_low_select = st.drv_low;
  assign pad_cfg.drive_mid_select = st.drv_mid;
  assign pad_cfg.drive_high_select = st.drv_high;
  assign pad_cfg.open_drain_select = st.open_drain;
  assign pad_cfg.pull_up_select = st.pull_up;
  assign pad_cfg.pull_down_select = st.pull_down;
  assign pad_cfg.slew_select = st.slew;
  assign pad_cfg.digital_input_enable = st.dig_en;
  assign irq = st.irq;
  assign adc_trig = st.adc_trig;

endmodule : gpb_port

// [gpb_port_test.sv]
// Purpose: self-checking bench of the port in port-B layout
// Assumes: bus tasks start just after a rising edge
// Notes: every wait is cut short by the cycle ceiling
`timescale 1ns/10ps
module gpb_port_test;
  logic clk, rst_b;
  gpb_pkg::gpb_axi_req_t req;
  gpb_pkg::gpb_axi_rsp_t rsp;
  logic [7:0] pin_in, pin_out, pin_oe, ext_val, per_out, per_oe, per_in;
  gpb_pkg::gpb_pad_t pad;
  logic irq, trig;
  int failures, samples_checked, cycles, trig_cnt;
  logic [39:0] rows [10];
  logic [19:0] rst_tab [8];
  logic [6:0] irq_tab [6];
  logic [6:0] m;
  logic [31:0] v;
  logic [1:0] r;
  gpb_port #(.PORT_KIND(gpb_pkg::PORT_B)) dut (.clk(clk), .rst_b(rst_b),
    .axi_req(req), .axi_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .periph_out(per_out), .periph_oe(per_oe),
    .periph_in(per_in), .pad_cfg(pad), .irq(irq), .adc_trig(trig));
  gpb_pins u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .pin_in(pin_in), .periph_out(per_out), .periph_oe(per_oe));
  // ----------
  // tasks
  // ----------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (trig === 1'b1) trig_cnt++;
    if (cycles == 6000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= gpb_pkg::STRB_ALL;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    while (rsp.bvalid !== 1'b1) @(posedge clk);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] s);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    s = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  // row: write address, data byte, read address, expected byte
  task automatic wrd(input logic [39:0] t);
    logic [31:0] g;
    logic [1:0] s;
    wr(t[39:28], {24'h00_0000, t[27:20]});
    // room for the four-flop pin synchroniser path to settle
    repeat (8) @(posedge clk);
    rd(t[19:8], g, s);
    chk("read data", {24'h00_0000, t[7:0]}, g);
    chk("read resp", {30'h0, gpb_pkg::RESP_OKAY}, {30'h0, s});
  endtask : wrd
  task automatic rst_chk();
    for (int i = 0; i < 8; i++) begin
      rd(rst_tab[i][19:8], v, r);
      chk("reset value", {24'h00_0000, rst_tab[i][7:0]}, v);
    end
    chk("reset drive", 32'h0000_0000, {24'h0, pin_oe & 8'h7F});
  endtask : rst_chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // ----------
  // sequence
  // ----------
  initial begin
    rst_b = 1'b0;
    req = '0;
    ext_val = 8'h50;
    rst_tab = '{{12'h400, 8'h00}, {12'h420, 8'h80}, {12'h510, 8'h80},
      {12'h51C, 8'h80}, {12'h514, 8'h00}, {12'h524, 8'h7F},
      {12'h500, 8'hFF}, {12'h520, 8'h01}};
    rows = '{{12'h51C, 8'hFF, 12'h51C, 8'hFF},
      {12'h400, 8'h0F, 12'h400, 8'h0F}, {12'h3FC, 8'h0A, 12'h1FC, 8'h5A},
      {12'h098, 8'h04, 12'h03C, 8'h0C}, {12'h414, 8'hFF, 12'h0C4, 8'h10},
      {12'h514, 8'h33, 12'h514, 8'h33}, {12'h518, 8'hC3, 12'h518, 8'hC3},
      {12'h504, 8'h0F, 12'h500, 8'hF0},
      {12'hFD0, 8'hFF, 12'hFD0, gpb_pkg::ID_BYTES[7:0]},
      {12'h50C, 8'h00, 12'hFFC, gpb_pkg::ID_BYTES[95:88]}};
    // sense, both, polarity, start level, end level, raw, raw later
    irq_tab = '{7'b001_0111, 7'b000_1011, 7'b010_1011, 7'b101_0110,
      7'b100_1010, 7'b001_1001};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rst_chk();
    foreach (rows[i]) begin
      wrd(rows[i]);
    end
    wrd({12'h420, 8'h00, 12'h420, 8'h80});
    wr(12'h520, gpb_pkg::GUARD_KEY);
    wrd({12'h524, 8'hFF, 12'h520, 8'h00});
    wrd({12'h420, 8'h00, 12'h524, 8'hFF});
    wrd({12'h520, 8'h00, 12'h420, 8'h00});
    wrd({12'h420, 8'h80, 12'h520, 8'h01});
    wrd({12'h420, 8'h81, 12'h420, 8'h01});
    chk("pin drive", 32'h0000_000D, {28'h0, pin_out[3:0]});
    chk("pin enable", 32'h0000_000F, {24'h00_0000, pin_oe});
    chk("periph in", 32'h0000_005D, {24'h0, per_in});
    chk("pad drive", 32'h0000_00F0, {24'h0, pad.drive_low_select});
    rd(12'h600, v, r);
    chk("unmapped resp", {30'h0, gpb_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0000_0000, v);
    wr(12'h600, 32'h0000_00FF);
    chk("write resp", {30'h0, gpb_pkg::RESP_SLVERR}, {30'h0, r});
    foreach (irq_tab[i]) begin
      m = irq_tab[i];
      wr(12'h410, 32'h0000_0000);
      wr(12'h404, {27'h0, m[6], 4'h0});
      wr(12'h408, {27'h0, m[5], 4'h0});
      wr(12'h40C, {27'h0, m[4], 4'h0});
      ext_val[4] <= m[3];
      repeat (8) @(posedge clk);
      wr(12'h41C, 32'h0000_00FF);
      ext_val[4] <= m[2];
      wrd({12'h410, 8'h00, 12'h414, 3'h0, m[1], 4'h0});
      wrd({12'h410, 8'h10, 12'h418, 3'h0, m[1], 4'h0});
      chk("port irq", {31'h0, m[1]}, {31'h0, irq});
      ext_val[4] <= m[3];
      wrd({12'h410, 8'h00, 12'h414, 3'h0, m[0], 4'h0});
    end
    wrd({12'h41C, 8'hEF, 12'h414, 8'h10});
    wrd({12'h41C, 8'h10, 12'h414, 8'h00});
    chk("trigger pulses", 32'h0000_0005, trig_cnt);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rst_chk();
    tally_and_finish();
  end
endmodule : gpb_port_test

// [gpb_props.sv]
// Purpose: bus, reset and trigger relations of the port
// Assumes: one clock, reset async and active low
// Notes: bound to every port instance
`timescale 1ns/10ps
module gpb_props #(
  parameter logic [1:0] PORT_KIND = gpb_pkg::PORT_PLAIN
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire gpb_pkg::gpb_axi_req_t axi_req,
  input wire gpb_pkg::gpb_axi_rsp_t axi_rsp,
  input wire logic [7:0] pin_oe,
  input wire gpb_pkg::gpb_pad_t pad_cfg,
  input wire logic irq,
  input wire logic adc_trig
);
  // ----------
  // relations
  // ----------
  // debug layout differs per port, so the mask follows the parameter
  localparam logic [7:0] DBG = (PORT_KIND == gpb_pkg::PORT_B) ?
    gpb_pkg::DBG_PINS_B : ((PORT_KIND == gpb_pkg::PORT_C) ?
    gpb_pkg::DBG_PINS_C : 8'h00);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence rd_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence b_take;
    axi_rsp.bvalid && axi_req.bready;
  endsequence
  wr_answer_a: assert property (
    wr_take |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write answer not two cycles after take");
  wr_block_a: assert property (
    wr_take |=> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write channels still ready after take");
  wr_free_a: assert property (
    b_take |=> !axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
    else $error("write answer not retired");
  rd_answer_a: assert property (
    rd_take |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer not one cycle after take");
  rd_done_a: assert property (
    axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid && axi_rsp.arready)
    else $error("read answer not retired");
  rst_plain_a: assert property ($rose(rst_b) |->
    (pin_oe & ~DBG) == 8'h00 && pad_cfg.pull_down_select == 8'h00
    && (pad_cfg.digital_input_enable & ~DBG) == 8'h00)
    else $error("ordinary pins not idle after reset");
  rst_debug_a: assert property ($rose(rst_b) |->
    pad_cfg.pull_up_select == DBG && pad_cfg.digital_input_enable == DBG)
    else $error("debug pins not in debug setup after reset");
  trig_pulse_a: assert property (adc_trig |=> !adc_trig)
    else $error("trigger longer than one cycle");
  trig_irq_a: assert property (adc_trig |-> irq)
    else $error("trigger without port interrupt");
endmodule : gpb_props

bind gpb_port gpb_props #(.PORT_KIND(PORT_KIND)) u_props (.clk(clk),
  .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp), .pin_oe(pin_oe),
  .pad_cfg(pad_cfg), .irq(irq), .adc_trig(adc_trig));

// [gpb_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pins are asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module gpb_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] async_in,
  output logic [7:0] level
);

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] level;
  } gpb_sync_t;

  gpb_sync_t st;
  gpb_sync_t next_st;

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change counts only once stages two and three agree
    next_st.level = (~(st.s2 ^ st.s3) & st.s3) |
                    ((st.s2 ^ st.s3) & st.level); // RULE_25
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule : gpb_sync
